// [src/bfs_defines.vh]
// constants for the breaker failure supervisor
`ifndef BFS_DEFINES_VH
`define BFS_DEFINES_VH
`define BFS_ADDR_CTRL 5'h00
`define BFS_ADDR_TIME 5'h04
`define BFS_ADDR_STAT 5'h08
`define BFS_ADDR_IRQS 5'h0C
`define BFS_ADDR_MASK 5'h10
`define BFS_ADDR_ACK 5'h14
`define BFS_CTRL_TRIG_LSB 0
`define BFS_CTRL_SCHEME_LSB 2
`define BFS_CTRL_EN_BIT 4
`define BFS_CTRL_RST 5'h00
`define BFS_TIME_MS 32'h0000_0064
`define BFS_CLK_KHZ 32'h0001_E848
`define BFS_TIME_RST (`BFS_TIME_MS * `BFS_CLK_KHZ)
`define BFS_TRIG_EVERY 2'h0
`define BFS_TRIG_OUTSIDE 2'h1
`define BFS_TRIG_OVERCUR 2'h2
`define BFS_TRIG_NONE 2'h3
`define BFS_SCH_CURRENT 2'h0
`define BFS_SCH_POSITION 2'h1
`define BFS_SCH_BOTH 2'h2
`define BFS_IRQ_START 0
`define BFS_IRQ_FAIL 1
`define BFS_IRQ_REJECT 2
`endif

// [src/bfs_sync.v]
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module bfs_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end
        else
        begin
          meta_ff[i] <= din[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
  assign dout = sync_ff;
endmodule // bfs_sync

// [src/bfs_breaker_failure.v]
// breaker failure supervisor with axi4-lite registers
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "bfs_defines.vh"
module bfs_breaker_failure (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // relay inputs
  input wire outsideTrip,
  input wire overcurrentTrip,
  input wire otherTrip,
  input wire extraTriggerInputA,
  input wire extraTriggerInputB,
  input wire extraTriggerInputC,
  input wire currentAboveThreshold,
  input wire breakerPosOpen,
  // relay outputs
  output reg failureTrip,
  output reg lockOut,
  output reg irq,
  // axi4-lite write address
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_REJECT = 2'd2;
  localparam ST_FAILED = 2'd3;

  wire [7:0] syncIn;
  wire sOutside;
  wire sOvercur;
  wire sOther;
  wire [2:0] sExtra;
  wire sCurHigh;
  wire sPosOpen;
  reg [4:0] ctrl_ff;
  reg [31:0] time_ff;
  reg [2:0] irqStat_ff;
  reg [2:0] irqMask_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] count_ff;
  reg [31:0] nxt_count;
  reg trigPrev_ff;
  reg [4:0] awAddr_ff;
  reg awHeld_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg wHeld_ff;
  reg selTrip;
  reg trigger;
  reg breakerOpen;
  reg [2:0] evt;
  wire doWrite;
  wire trigRise;
  wire [31:0] ctrlMerged;

  bfs_sync #(
    .WIDTH(8)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({breakerPosOpen, currentAboveThreshold, extraTriggerInputC,
      extraTriggerInputB, extraTriggerInputA, otherTrip,
      overcurrentTrip, outsideTrip}),
    .dout(syncIn)
  );
  assign sOutside = syncIn[0];
  assign sOvercur = syncIn[1];
  assign sOther = syncIn[2];
  assign sExtra = syncIn[5:3];
  assign sCurHigh = syncIn[6];
  assign sPosOpen = syncIn[7];

  // byte-lane merge of a write into a stored word
  function [31:0] mergeBytes;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      mergeBytes = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          mergeBytes[b*8 +: 8] = data[b*8 +: 8];
    end
  endfunction

  // control word widened for the lane merge
  assign ctrlMerged = mergeBytes({27'h0, ctrl_ff}, wData_ff, wStrb_ff);

  always @*
  begin
    case (ctrl_ff[`BFS_CTRL_TRIG_LSB +: 2])
      `BFS_TRIG_EVERY: selTrip = sOutside | sOvercur | sOther;
      `BFS_TRIG_OUTSIDE: selTrip = sOutside;
      `BFS_TRIG_OVERCUR: selTrip = sOvercur;
      default: selTrip = 1'b0;
    endcase
    trigger = ctrl_ff[`BFS_CTRL_EN_BIT] & (selTrip | (|sExtra));
    case (ctrl_ff[`BFS_CTRL_SCHEME_LSB +: 2])
      `BFS_SCH_CURRENT: breakerOpen = ~sCurHigh;
      `BFS_SCH_POSITION: breakerOpen = sPosOpen;
      default: breakerOpen = ~sCurHigh & sPosOpen;
    endcase
  end

  assign trigRise = trigger & ~trigPrev_ff;

  always @*
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    evt = 3'b000;
    case (state_ff)
      ST_IDLE:
      begin
        // start only on fresh trigger with breaker closed
        if (trigRise && !breakerOpen)
        begin
          nxt_state = ST_RUN;
          nxt_count = time_ff;
          evt[`BFS_IRQ_START] = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (breakerOpen)
        begin
          nxt_state = trigger ? ST_REJECT : ST_IDLE;
          evt[`BFS_IRQ_REJECT] = trigger;
        end
        else if (count_ff <= 32'h0000_0001)
        begin
          nxt_state = ST_FAILED;
          evt[`BFS_IRQ_FAIL] = 1'b1;
        end
        else
          nxt_count = count_ff - 32'h0000_0001;
      end
      ST_REJECT:
      begin
        if (!trigger)
          nxt_state = ST_IDLE;
      end
      default:
      begin
        // back to stand-by once triggers gone
        if (!trigger)
          nxt_state = ST_IDLE;
      end
    endcase
  end

  assign doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      count_ff <= 32'h0000_0000;
      trigPrev_ff <= 1'b0;
      failureTrip <= 1'b0;
      lockOut <= 1'b0;
      irq <= 1'b0;
      ctrl_ff <= `BFS_CTRL_RST;
      time_ff <= `BFS_TIME_RST;
      irqStat_ff <= 3'b000;
      irqMask_ff <= 3'b000;
      awAddr_ff <= 5'h00;
      awHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      wHeld_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      trigPrev_ff <= trigger;
      failureTrip <= (nxt_state == ST_FAILED);
      irq <= |(irqStat_ff & irqMask_ff);
      // write channel capture, either order
      s_axi_awready <= ~awHeld_ff & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_ff <= s_axi_awaddr;
        awHeld_ff <= 1'b1;
      end
      s_axi_wready <= ~wHeld_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHeld_ff <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // lock set with trip; ack clears unless trip sets it again
      if (nxt_state == ST_FAILED && state_ff != ST_FAILED)
        lockOut <= 1'b1;
      else if (doWrite && awAddr_ff == `BFS_ADDR_ACK && wStrb_ff[0]
        && wData_ff[0])
        lockOut <= 1'b0;
      // sticky status, set beats write-one-to-clear
      if (doWrite && awAddr_ff == `BFS_ADDR_IRQS && wStrb_ff[0])
        irqStat_ff <= (irqStat_ff & ~wData_ff[2:0]) | evt;
      else
        irqStat_ff <= irqStat_ff | evt;
      if (doWrite)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (awAddr_ff == `BFS_ADDR_CTRL)
          ctrl_ff <= ctrlMerged[4:0];
        else if (awAddr_ff == `BFS_ADDR_TIME)
          time_ff <= mergeBytes(time_ff, wData_ff, wStrb_ff);
        else if (awAddr_ff == `BFS_ADDR_MASK)
        begin
          if (wStrb_ff[0])
            irqMask_ff <= wData_ff[2:0];
        end
        else if (awAddr_ff == `BFS_ADDR_IRQS || awAddr_ff == `BFS_ADDR_ACK)
          s_axi_bresp <= 2'b00;
        else
          s_axi_bresp <= 2'b10;
      end
      // read channel
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (s_axi_araddr == `BFS_ADDR_CTRL)
          s_axi_rdata <= {27'h0, ctrl_ff};
        else if (s_axi_araddr == `BFS_ADDR_TIME)
          s_axi_rdata <= time_ff;
        else if (s_axi_araddr == `BFS_ADDR_STAT)
          s_axi_rdata <= {28'h0, lockOut, failureTrip, state_ff};
        else if (s_axi_araddr == `BFS_ADDR_IRQS)
          s_axi_rdata <= {29'h0, irqStat_ff};
        else if (s_axi_araddr == `BFS_ADDR_MASK)
          s_axi_rdata <= {29'h0, irqMask_ff};
        else if (s_axi_araddr == `BFS_ADDR_ACK)
          s_axi_rdata <= 32'h0000_0000;
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end
    end
  end
endmodule // bfs_breaker_failure

// [test/bfs_checker_sva.sv]
// assertion checker for the breaker failure supervisor
`timescale 1ns/1ns
module bfs_checker (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // trigger pins
  input wire outsideTrip,
  input wire overcurrentTrip,
  input wire otherTrip,
  input wire extraTriggerInputA,
  input wire extraTriggerInputB,
  input wire extraTriggerInputC,
  // relay outputs
  input wire failureTrip,
  input wire lockOut,
  // bus
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  wire anyTrig;
  assign anyTrig = outsideTrip | overcurrentTrip | otherTrip |
    extraTriggerInputA | extraTriggerInputB | extraTriggerInputC;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_lockTrip;
    $rose(failureTrip) |-> lockOut;
  endproperty
  a_lockTrip: assert property (p_lockTrip) else $error("no lock");
  property p_lockHold;
    $fell(lockOut) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) ||
      $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4);
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("lock lost");
  property p_tripHold;
    failureTrip && extraTriggerInputA |=> failureTrip;
  endproperty
  a_tripHold: assert property (p_tripHold) else $error("trip lost");
  property p_tripDrop;
    (!anyTrig) [*6] ##1 (!anyTrig && failureTrip) |=> !failureTrip;
  endproperty
  a_tripDrop: assert property (p_tripDrop) else $error("trip stuck");
  property p_noFast;
    $rose(anyTrig) |-> (!$rose(failureTrip)) [*8];
  endproperty
  a_noFast: assert property (p_noFast) else $error("trip too soon");
  property p_rstQuiet;
    $fell(rst) |-> !failureTrip && !lockOut;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("reset");
  property p_bOnce;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bOnce: assert property (p_bOnce) else $error("bvalid twice");
  property p_arAns;
    s_axi_arvalid |-> ##[0:4] s_axi_arready;
  endproperty
  a_arAns: assert property (p_arAns) else $error("no arready");
  property p_rAfter;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rAfter: assert property (p_rAfter) else $error("no rvalid");
endmodule // bfs_checker
bind bfs_breaker_failure bfs_checker u_chk (.ref_clk, .rst, .outsideTrip,
  .overcurrentTrip, .otherTrip, .extraTriggerInputA, .extraTriggerInputB,
  .extraTriggerInputC, .failureTrip, .lockOut, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// [test/bfs_relay_model.sv]
// trip logic and breaker model on the relay side
`timescale 1ns/1ns
module bfs_relay_model #(
  parameter OPEN_DLY = 8
) (
  // clock
  input wire ref_clk,
  // bench commands
  input wire [5:0] tripCmd,
  input wire curStuck,
  input wire posStuck,
  // relay pins
  output wire [5:0] trips,
  output reg currentAboveThreshold,
  output reg breakerPosOpen
);
  integer openCnt_ff = 0;
  assign trips = tripCmd;
  initial currentAboveThreshold = 1'b1;
  initial breakerPosOpen = 1'b0;
  // opens before supervision time unless posStuck, current falls unless curStuck
  always @(posedge ref_clk)
  begin
    if (tripCmd == 6'h00)
    begin
      openCnt_ff <= 0;
      currentAboveThreshold <= 1'b1;
      breakerPosOpen <= 1'b0;
    end
    else if (openCnt_ff < OPEN_DLY)
      openCnt_ff <= openCnt_ff + 1;
    else
    begin
      currentAboveThreshold <= curStuck;
      breakerPosOpen <= !posStuck;
    end
  end
endmodule // bfs_relay_model

// [test/tb_top.sv]
// self-checking bench for the breaker failure supervisor
`timescale 1ns/1ns
`include "bfs_defines.vh"
module tb_top;
  logic ref_clk = 0, rst = 1, curStuck = 0, posStuck = 0;
  logic [5:0] tripCmd = 0, trips;
  logic currentAboveThreshold, breakerPosOpen, failureTrip, lockOut, irq;
  logic [4:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, bvalid;
  logic arready, rvalid;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rr, br;
  logic [12:0] rows [10] = '{13'h0025, 13'h0010, 13'h080D, 13'h0814,
    13'h1213, 13'h120A, 13'h1845, 13'h1C85, 13'h1D00, 13'h180C};
  int err_count = 0, cmp_count = 0, cyc = 0;
  bfs_relay_model u_far (.ref_clk, .tripCmd, .curStuck, .posStuck, .trips,
    .currentAboveThreshold, .breakerPosOpen);
  bfs_breaker_failure DUT (.ref_clk, .rst, .outsideTrip(trips[0]),
    .overcurrentTrip(trips[1]), .otherTrip(trips[2]),
    .extraTriggerInputA(trips[3]), .extraTriggerInputB(trips[4]),
    .extraTriggerInputC(trips[5]), .currentAboveThreshold, .breakerPosOpen,
    .failureTrip, .lockOut, .irq, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1));
  initial forever #4 ref_clk = ~ref_clk;
  task test_done;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task axw(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    fork
      begin
        do @(posedge ref_clk); while (awready !== 1'b1);
        awvalid <= 0;
      end
      begin
        do @(posedge ref_clk); while (wready !== 1'b1);
        wvalid <= 0;
      end
    join
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    br = bresp;
  endtask
  task axr(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      test_done;
    end
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    axr(`BFS_ADDR_CTRL);
    chk("ctrl", rd, `BFS_CTRL_RST);
    axr(`BFS_ADDR_TIME);
    chk("time", rd, 32'h00BE_BC20);
    axr(5'h18);
    chk("resp", rr, 2'b10);
    chk("data", rd, 32'h0000_0000);
    axw(`BFS_ADDR_TIME, 32'h0000_0014);
    chk("bresp", br, 2'b00);
    axw(5'h18, 32'h0000_0000);
    chk("bresp err", br, 2'b10);
    axw(`BFS_ADDR_MASK, 32'h0000_0002);
    for (int i = 0; i < 10; i++)
    begin
      axw(`BFS_ADDR_CTRL, {27'h0, 1'b1, rows[i][10:9], rows[i][12:11]});
      tripCmd <= rows[i][8:3];
      curStuck <= rows[i][2];
      posStuck <= rows[i][1];
      repeat (60) @(posedge ref_clk);
      chk("trip", failureTrip, rows[i][0]);
      chk("lock", lockOut, rows[i][0]);
      chk("irq", irq, rows[i][0]);
      tripCmd <= 0;
      repeat (8) @(posedge ref_clk);
      chk("trip off", failureTrip, 0);
      chk("lock kept", lockOut, rows[i][0]);
      axw(`BFS_ADDR_ACK, 32'h0000_0001);
      axw(`BFS_ADDR_IRQS, 32'h0000_0007);
      repeat (2) @(posedge ref_clk);
      chk("lock ack", lockOut, 0);
      chk("irq clr", irq, 0);
    end
    axw(`BFS_ADDR_CTRL, 32'h0000_0010);
    tripCmd <= 6'h01;
    curStuck <= 1;
    repeat (4) @(posedge ref_clk);
    tripCmd <= 0;
    repeat (14) @(posedge ref_clk);
    chk("early", lockOut, 0);
    repeat (42) @(posedge ref_clk);
    chk("runs on", lockOut, 1);
    // breaker opens under a held trigger, then fresh trigger while breaker already open
    axw(`BFS_ADDR_ACK, 32'h0000_0001);
    axw(`BFS_ADDR_CTRL, 32'h0000_0011);
    tripCmd <= 6'h01;
    curStuck <= 0;
    repeat (24) @(posedge ref_clk);
    axr(`BFS_ADDR_STAT);
    chk("reject", rd, 32'h0000_0002);
    tripCmd <= 6'h02;
    repeat (6) @(posedge ref_clk);
    axw(`BFS_ADDR_IRQS, 32'h0000_0007);
    tripCmd <= 6'h01;
    repeat (8) @(posedge ref_clk);
    axr(`BFS_ADDR_STAT);
    chk("stat", rd, 32'h0000_0000);
    axr(`BFS_ADDR_IRQS);
    chk("no start", rd, 32'h0000_0000);
    test_done;
  end
endmodule // tb_top
